// file: core/asr_pkg.sv
// asr_pkg: constants and types shared by the sram host controller
// assumes a 250 MHz clock (4 ns period) and the faster speed grade
`default_nettype none
package asr_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 4;
   localparam int unsigned ADDR_W         = 18;
   localparam int unsigned DATA_W         = 16;
   localparam int unsigned LANE_W         = 8;
   // timing figures, faster grade
   localparam int unsigned T_POWER_US     = 100;
   localparam int unsigned T_RC_NS        = 10;
   localparam int unsigned T_AA_NS        = 10;
   localparam int unsigned T_ACE_NS       = 10;
   localparam int unsigned T_DOE_NS       = 5;
   localparam int unsigned T_DBE_NS       = 5;
   localparam int unsigned T_HZ_NS        = 5;
   localparam int unsigned T_WC_NS        = 10;
   localparam int unsigned T_PWE_NS       = 7;
   localparam int unsigned T_BW_NS        = 7;
   localparam int unsigned T_SD_NS        = 6;
   // least times round up to whole cycles
   localparam int unsigned POWER_CYC      = (T_POWER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RD_MAX_NS      = (T_AA_NS > T_ACE_NS) ? T_AA_NS : T_ACE_NS;
   localparam int unsigned RD_CYC         = (RD_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WR_MIN_NS      = (T_PWE_NS > T_BW_NS) ? T_PWE_NS : T_BW_NS;
   localparam int unsigned WR_CYC         = (WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HZ_CYC         = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RC_CYC         = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WC_CYC         = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W          = 16;
   localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
   typedef enum logic [2:0] {
      ASR_ST_POWER,
      ASR_ST_IDLE,
      ASR_ST_READ,
      ASR_ST_WRITE,
      ASR_ST_RECOVER
   } asr_state_t;
endpackage
`default_nettype wire

// file: core/asr_timer_if.sv
// asr_timer_if: load/expiry handshake between controller and its delay timer
// assumes both ends share MCLK and RST_B
`default_nettype none
interface asr_timer_if;
   import asr_pkg::*;
   logic             load;
   logic [CNT_W-1:0] count;
   logic             done;
   modport ctrl  (output load, output count, input done);
   modport timer (input load, input count, output done);
endinterface
`default_nettype wire

// file: core/asr_timer.sv
// asr_timer: down counter; done is high while no delay is pending
// assumes load is a one-cycle pulse with count of at least one
`default_nettype none
module asr_timer
   import asr_pkg::*;
(
   input  wire logic  MCLK,
   input  wire logic  RST_B,
   asr_timer_if.timer tif
);
   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         cnt_r <= '0;
      end else if (tif.load) begin
         cnt_r <= tif.count;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - CNT_ONE;
      end
   end

   assign tif.done = (cnt_r == '0) && !tif.load;
endmodule
`default_nettype wire

// file: core/asr_host.sv
// asr_host: host controller driving an asynchronous 256K x 16 static ram
// assumes the sram pins sit on MCLK timing; data pins are split in/out/oe
//
// Functional notes
// - write only while select and strobe low
// - read: select and gate low, strobe high
// - byte select low before write end
// - wait 100 us before first access
// - write ends by raising write strobe
// - drive data only after device releases
`default_nettype none
module asr_host
   import asr_pkg::*;
#(
   parameter int unsigned POWER_CYCLES = POWER_CYC
)(
   input  wire logic              MCLK,
   input  wire logic              RST_B,
   // user side
   input  wire logic              REQ_VALID,
   input  wire logic              REQ_WRITE,
   input  wire logic [ADDR_W-1:0] REQ_ADDR,
   input  wire logic [DATA_W-1:0] REQ_WDATA,
   input  wire logic [1:0]        REQ_LANES,
   output var  logic              REQ_READY,
   output var  logic              RSP_VALID,
   output var  logic [DATA_W-1:0] RSP_RDATA,
   // sram pins
   output var  logic [ADDR_W-1:0] SRAM_ADDR,
   output var  logic              SRAM_CHIP_SELECT_N,
   output var  logic              SRAM_WRITE_STROBE_N,
   output var  logic              SRAM_OUTPUT_GATE_N,
   output var  logic              SRAM_LOW_BYTE_SELECT_N,
   output var  logic              SRAM_HIGH_BYTE_SELECT_N,
   input  wire logic [DATA_W-1:0] SRAM_DQ_IN,
   output var  logic [DATA_W-1:0] SRAM_DQ_OUT,
   output var  logic              SRAM_DQ_OE
);
   asr_timer_if tif ();
   asr_timer u_timer (
      .MCLK  (MCLK),
      .RST_B (RST_B),
      .tif   (tif)
   );

   asr_state_t       state_r;
   logic             load_r;
   logic [CNT_W-1:0] count_r;
   logic [DATA_W-1:0] dq_s1_r;
   logic [DATA_W-1:0] dq_s2_r;
   logic [DATA_W-1:0] dq_s3_r;

   assign tif.load  = load_r;
   assign tif.count = count_r;

   // ----------------------------------------------------------------
   // read data capture stages
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         dq_s1_r <= '0;
         dq_s2_r <= '0;
         dq_s3_r <= '0;
      end else begin
         dq_s1_r <= SRAM_DQ_IN;
         dq_s2_r <= dq_s1_r;
         dq_s3_r <= dq_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r                 <= ASR_ST_POWER;
         load_r                  <= 1'b1;
         count_r                 <= CNT_W'(POWER_CYCLES);
         REQ_READY               <= 1'b0;
         RSP_VALID               <= 1'b0;
         RSP_RDATA               <= '0;
         SRAM_ADDR               <= '0;
         SRAM_CHIP_SELECT_N      <= 1'b1;
         SRAM_WRITE_STROBE_N     <= 1'b1;
         SRAM_OUTPUT_GATE_N      <= 1'b1;
         SRAM_LOW_BYTE_SELECT_N  <= 1'b1;
         SRAM_HIGH_BYTE_SELECT_N <= 1'b1;
         SRAM_DQ_OUT             <= '0;
         SRAM_DQ_OE              <= 1'b0;
      end else begin
         load_r    <= 1'b0;
         RSP_VALID <= 1'b0;
         unique case (state_r)
            ASR_ST_POWER: begin
               if (!load_r && tif.done) begin
                  state_r   <= ASR_ST_IDLE;
                  REQ_READY <= 1'b1;
               end
            end
            ASR_ST_IDLE: begin
               if (REQ_VALID) begin
                  REQ_READY <= 1'b0;
                  // address and lanes held for the access
                  SRAM_ADDR               <= REQ_ADDR;
                  SRAM_LOW_BYTE_SELECT_N  <= !REQ_LANES[0];
                  SRAM_HIGH_BYTE_SELECT_N <= !REQ_LANES[1];
                  SRAM_CHIP_SELECT_N      <= 1'b0;
                  load_r                  <= 1'b1;
                  if (REQ_WRITE) begin
                     state_r             <= ASR_ST_WRITE;
                     SRAM_WRITE_STROBE_N <= 1'b0;
                     SRAM_DQ_OUT         <= REQ_WDATA;
                     SRAM_DQ_OE          <= 1'b1;
                     count_r             <= CNT_W'(WR_CYC + 1);
                  end else begin
                     // read with gate low, strobe high
                     state_r            <= ASR_ST_READ;
                     SRAM_OUTPUT_GATE_N <= 1'b0;
                     count_r            <= CNT_W'(RD_CYC + 2);
                  end
               end
            end
            ASR_ST_READ: begin
               if (!load_r && tif.done) begin
                  RSP_RDATA           <= dq_s3_r;
                  RSP_VALID           <= 1'b1;
                  SRAM_OUTPUT_GATE_N  <= 1'b1;
                  SRAM_CHIP_SELECT_N  <= 1'b1;
                  SRAM_LOW_BYTE_SELECT_N  <= 1'b1;
                  SRAM_HIGH_BYTE_SELECT_N <= 1'b1;
                  state_r             <= ASR_ST_RECOVER;
                  load_r              <= 1'b1;
                  count_r             <= CNT_W'(HZ_CYC + RC_CYC);
               end
            end
            ASR_ST_WRITE: begin
               if (!load_r && tif.done) begin
                  SRAM_WRITE_STROBE_N     <= 1'b1;
                  SRAM_CHIP_SELECT_N      <= 1'b1;
                  SRAM_LOW_BYTE_SELECT_N  <= 1'b1;
                  SRAM_HIGH_BYTE_SELECT_N <= 1'b1;
                  state_r                 <= ASR_ST_RECOVER;
                  load_r                  <= 1'b1;
                  count_r                 <= CNT_W'(WC_CYC);
               end
            end
            ASR_ST_RECOVER: begin
               SRAM_DQ_OE <= 1'b0;
               if (!load_r && tif.done) begin
                  state_r   <= ASR_ST_IDLE;
                  REQ_READY <= 1'b1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // write strobe only under select
   wr_under_cs_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      !SRAM_WRITE_STROBE_N |-> !SRAM_CHIP_SELECT_N)
      else $error("write strobe low without chip select");

   // gate and strobe never both low
   rd_no_wr_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      !SRAM_OUTPUT_GATE_N |-> SRAM_WRITE_STROBE_N)
      else $error("output gate low during write");

   no_fight_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      SRAM_DQ_OE |-> SRAM_OUTPUT_GATE_N)
      else $error("host drives data while gate low");

   wr_width_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      $fell(SRAM_WRITE_STROBE_N) |-> !SRAM_WRITE_STROBE_N [*3])
      else $error("write pulse too short");

   wr_lanes_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      !SRAM_WRITE_STROBE_N && !$fell(SRAM_WRITE_STROBE_N) |->
         $stable(SRAM_LOW_BYTE_SELECT_N) && $stable(SRAM_HIGH_BYTE_SELECT_N))
      else $error("byte select moved during write");

   wr_data_on_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      !SRAM_WRITE_STROBE_N |-> SRAM_DQ_OE)
      else $error("write strobe low without data driven");

   wr_end_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      $rose(SRAM_WRITE_STROBE_N) |-> $rose(SRAM_CHIP_SELECT_N))
      else $error("write ended without deselect");

   addr_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      !SRAM_CHIP_SELECT_N && $past(!SRAM_CHIP_SELECT_N) |-> $stable(SRAM_ADDR))
      else $error("address moved during access");

   rd_wait_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      $fell(SRAM_OUTPUT_GATE_N) |-> ##[4:8] RSP_VALID)
      else $error("read response timing wrong");

   pwr_wait_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      state_r == ASR_ST_POWER |-> SRAM_CHIP_SELECT_N && !REQ_READY)
      else $error("access during power wait");
endmodule
`default_nettype wire

// file: verif/asr_sram_model.sv
// asr_sram_model: behavioural 256K x 16 asynchronous static ram
// assumes host pins change on clock edges; slow picks the longer access delay
`default_nettype none
module asr_sram_model
   import asr_pkg::*;
(
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              cs_n,
   input  wire logic              we_n,
   input  wire logic              oe_n,
   input  wire logic              lb_n,
   input  wire logic              hb_n,
   input  wire logic [DATA_W-1:0] host_dq,
   input  wire logic              host_oe,
   input  wire logic              slow,
   output var  logic [DATA_W-1:0] dq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] w, rd_q, flt;
   logic [1:0]        drv, drv_q;
   // worst-case access time of the slower grade
   localparam int unsigned ACC_SLOW_NS = 12;
   initial begin
      drv_q = 2'b00;
      flt = 16'h5A3C;
      forever #2 flt = ~flt;
   end
   always @(addr or cs_n or we_n or oe_n or lb_n or hb_n or host_dq) begin
      w = mem.exists(addr) ? mem[addr] : addr[15:0] ^ 16'hA5A5;
      if (!cs_n && !we_n && !lb_n) w[7:0] = host_dq[7:0];
      if (!cs_n && !we_n && !hb_n) w[15:8] = host_dq[15:8];
      if (!cs_n && !we_n) mem[addr] = w;
      drv = {!hb_n, !lb_n} & {2{!cs_n && !oe_n && we_n}};
      rd_q <= #(slow ? ACC_SLOW_NS : T_AA_NS) w;
      drv_q <= #(slow ? 5 : 3) drv;
   end
   always @* begin
      for (int i = 0; i < 2; i++) begin
         if (host_oe) dq[i*8 +: 8] = drv_q[i] ? 8'hXX : host_dq[i*8 +: 8];
         else dq[i*8 +: 8] = drv_q[i] ? rd_q[i*8 +: 8] : flt[i*8 +: 8];
      end
   end
endmodule
`default_nettype wire

// file: verif/asr_host_tb.sv
// asr_host_tb: self-checking bench for the sram host controller
// assumes the behavioural sram model on the pin side
`default_nettype none
module asr_host_tb
   import asr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned PWR = 20;
   logic              mclk, rst_b, req_valid, req_write, slow, req_ready, rsp_valid;
   logic              cs_n, we_n, oe_n, lb_n, hb_n, dq_oe;
   logic [ADDR_W-1:0] req_addr, s_addr;
   logic [DATA_W-1:0] req_wdata, rsp_rdata, dq_out, dq;
   logic [1:0]        req_lanes;
   int                fails, tests_run;
   asr_host #(.POWER_CYCLES(PWR)) i_asr_host (.MCLK(mclk), .RST_B(rst_b),
      .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
      .REQ_WDATA(req_wdata), .REQ_LANES(req_lanes), .REQ_READY(req_ready),
      .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .SRAM_ADDR(s_addr),
      .SRAM_CHIP_SELECT_N(cs_n), .SRAM_WRITE_STROBE_N(we_n), .SRAM_OUTPUT_GATE_N(oe_n),
      .SRAM_LOW_BYTE_SELECT_N(lb_n), .SRAM_HIGH_BYTE_SELECT_N(hb_n),
      .SRAM_DQ_IN(dq), .SRAM_DQ_OUT(dq_out), .SRAM_DQ_OE(dq_oe));
   asr_sram_model i_asr_sram_model (.addr(s_addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
      .lb_n(lb_n), .hb_n(hb_n), .host_dq(dq_out), .host_oe(dq_oe), .slow(slow), .dq(dq));
   // ----------------------------------------
   // checks and bus tasks
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [1:0] ln);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      req_lanes = ln;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      check_val(16'(req_ready), 16'h0001);
      @(negedge mclk);
      req_valid = 1'b0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [1:0] ln);
      issue(1'b1, a, d, ln);
      @(negedge mclk);
      check_val(16'({cs_n, we_n, dq_oe, hb_n, lb_n}), 16'({3'b001, ~ln}));
      check_val(dq_out, d);
      check_val(16'(s_addr != a), 16'h0000);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] ln,
                     input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] m;
      int n;
      m = {{8{ln[1]}}, {8{ln[0]}}};
      n = 0;
      issue(1'b0, a, 16'h0000, ln);
      while (rsp_valid !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
         if (n == 1) check_val(16'({cs_n, we_n, oe_n, dq_oe}), 16'h0004);
      end
      check_val(16'(n), 16'h0007);
      check_val(rsp_rdata & m, exp & m);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power();
      int n;
      n = 0;
      check_val(16'({cs_n, we_n, oe_n, dq_oe}), 16'h000E);
      while (req_ready !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      check_val(16'(n >= PWR), 16'h0001);
      check_val(16'(req_ready), 16'h0001);
   endtask
   task automatic t_full();
      wr(18'h00000, 16'hC3A5, 2'b11);
      wr(18'h3FFFF, 16'h5E71, 2'b11);
      rd(18'h3FFFF, 2'b11, 16'h5E71);
      rd(18'h00000, 2'b11, 16'hC3A5);
   endtask
   task automatic t_lanes();
      wr(18'h12345, 16'h1234, 2'b11);
      wr(18'h12345, 16'h77CD, 2'b01);
      wr(18'h12345, 16'hEF88, 2'b10);
      rd(18'h12345, 2'b01, 16'h00CD);
      rd(18'h12345, 2'b10, 16'hEF00);
      rd(18'h12345, 2'b11, 16'hEFCD);
   endtask
   task automatic t_slow();
      slow = 1'b1;
      wr(18'h2AAAA, 16'h9B26, 2'b11);
      rd(18'h2AAAA, 2'b11, 16'h9B26);
      rd(18'h00000, 2'b10, 16'hC300);
      slow = 1'b0;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      #20000;
      fails++;
      tally_and_finish();
   end
   initial begin
      rst_b = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 18'h00000;
      req_wdata = 16'h0000;
      req_lanes = 2'b00;
      slow = 1'b0;
      fails = 0;
      tests_run = 0;
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      t_power();
      t_full();
      t_lanes();
      t_slow();
      tally_and_finish();
   end
endmodule
`default_nettype wire
